// *** design/haf_ack.v ***
// Purpose: Acknowledge sequencing for host accesses
// Assumes: Host strobes already synchronised to aclk
// Notes:   ack_n low completes an access, high holds it off
`timescale 1ns/10ps

// ==========================================================
// Acknowledge controller
module haf_ack
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Synchronised host strobes
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire cdata_sel,
    // FIFO and mode
    input wire decode_mode,
    input wire fifo_full,
    input wire fifo_empty,
    // Results
    output reg ack_n,
    output reg wr_commit,
    output wire rd_active
);

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_WAIT = 4'h2;
localparam [3:0] ST_STALL = 4'h4;
localparam [3:0] ST_DONE = 4'h8;

reg [3:0] state;
reg [3:0] next_state;
reg wr_n_d;
wire access;
wire stall;

assign access = !cs_n && (!wr_n || !rd_n);
// Full FIFO holds decode writes, empty FIFO holds encode reads
assign stall = cdata_sel &&
    ((decode_mode && !wr_n && fifo_full) ||
     (!decode_mode && !rd_n && fifo_empty));
assign rd_active = !cs_n && !rd_n;

always @*
begin
    next_state = state;
    case (state)
        ST_IDLE:
            if (access)
            begin
                if (!cdata_sel)
                    next_state = ST_WAIT;
                else if (stall)
                    next_state = ST_STALL;
                else
                    next_state = ST_DONE;
            end
        ST_WAIT:
            next_state = ST_DONE;
        ST_STALL:
            if (!access)
                next_state = ST_IDLE;
            else if (!stall)
                next_state = ST_DONE;
        ST_DONE:
            if (!access)
                next_state = ST_IDLE;
        default:
            next_state = ST_IDLE;
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        state <= ST_IDLE;
        ack_n <= 1'b1;
        wr_n_d <= 1'b1;
        wr_commit <= 1'b0;
    end
    else
    begin
        state <= next_state;
        ack_n <= (next_state != ST_DONE);
        wr_n_d <= wr_n;
        // Write lands on the strobe's rising edge, only once acked
        wr_commit <= wr_n && !wr_n_d && !cs_n &&
            (state == ST_DONE);
    end
end

endmodule // haf_ack

// *** design/haf_sync.v ***
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs change asynchronously to aclk
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps

// ==========================================================
// Synchroniser
module haf_sync
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Data
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] stage1;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        stage1 <= RESET_VAL;
        q <= RESET_VAL;
    end
    else
    begin
        stage1 <= d;
        q <= stage1;
    end
end

endmodule // haf_sync

// *** design/haf_top.v ***
// Purpose: Host acknowledge, FIFO service request and statistics ready
// Assumes: FIFO level, full, empty and stats pulses from aclk logic
// Notes:   Host pins pass a two-stage synchroniser, except for the data output enable
//
// Overview of operation
// - Acknowledge low marks a finished host access
// - Non-FIFO accesses get at least one wait
// - Decode full FIFO holds writes via acknowledge
// - Encode empty FIFO holds reads via acknowledge
// - Service request high when FIFO needs host
// - Service request mirrored in interrupt status
// - Encode: request low after reset, rises nearly-full
// - Decode: request low after reset, high while at or below nearly-empty
// - Statistics ready rises when statistics updated
// - Statistics ready occurs once per field
// - Statistics ready mirrored in interrupt status
// - Writes on strobe rise, reads while low
`timescale 1ns/10ps
`include "haf_regs.vh"

// ==========================================================
// Top level
module haf_top
#(
    parameter LEVEL_W = 10
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [`HAF_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`HAF_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Host pins
    input wire host_cs_n,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire host_cdata_sel,
    input wire [31:0] host_data_i,
    output reg [31:0] host_data_o,
    output wire host_data_oe,
    output wire host_ack_n,
    // Core side
    input wire [LEVEL_W-1:0] fifo_level,
    input wire fifo_full,
    input wire fifo_empty,
    input wire stats_update,
    input wire stats_read,
    input wire [31:0] core_rdata,
    output reg [31:0] host_wr_data,
    output reg host_wr_pulse,
    output reg host_cdata_push,
    output reg host_cdata_pop,
    output wire software_reset_bit,
    output wire decode_mode,
    // Status outputs
    output reg fifo_service_request,
    output reg statistics_ready,
    output wire host_interrupt_request
);

// ==========================================================
// Register decode
function hit;
    input [`HAF_ADDR_W-1:0] addr;
    input [`HAF_ADDR_W-1:0] offset;
    begin
        hit = (addr[`HAF_ADDR_W-1:2] == offset[`HAF_ADDR_W-1:2]);
    end
endfunction

// ==========================================================
// Pin synchronisers
wire cs_n_s;
wire wr_n_s;
wire rd_n_s;
wire cdata_sel_s;
wire [31:0] data_s;

haf_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_strobe
(
    .aclk(aclk),
    .aresetn(aresetn),
    .d({host_cs_n, host_wr_n, host_rd_n}),
    .q({cs_n_s, wr_n_s, rd_n_s})
);

haf_sync #(.WIDTH(33), .RESET_VAL(33'h0)) u_sync_data
(
    .aclk(aclk),
    .aresetn(aresetn),
    .d({host_cdata_sel, host_data_i}),
    .q({cdata_sel_s, data_s})
);

// ==========================================================
// Acknowledge controller
wire wr_commit;
wire rd_active;
reg rd_active_d;

haf_ack u_ack
(
    .aclk(aclk),
    .aresetn(aresetn),
    .cs_n(cs_n_s),
    .wr_n(wr_n_s),
    .rd_n(rd_n_s),
    .cdata_sel(cdata_sel_s),
    .decode_mode(decode_mode),
    .fifo_full(fifo_full),
    .fifo_empty(fifo_empty),
    .ack_n(host_ack_n),
    .wr_commit(wr_commit),
    .rd_active(rd_active)
);

// Data pins float whenever chip select is high
assign host_data_oe = !host_cs_n && !host_rd_n;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        host_data_o <= 32'h0000_0000;
        host_wr_data <= 32'h0000_0000;
        host_wr_pulse <= 1'b0;
        host_cdata_push <= 1'b0;
        host_cdata_pop <= 1'b0;
        rd_active_d <= 1'b0;
    end
    else
    begin
        rd_active_d <= rd_active;
        if (rd_active)
            host_data_o <= core_rdata;
        host_wr_pulse <= wr_commit;
        if (wr_commit)
            host_wr_data <= data_s;
        host_cdata_push <= wr_commit && cdata_sel_s;
        // Pop only once the read strobe is released
        host_cdata_pop <= rd_active_d && !rd_active && cdata_sel_s;
    end
end

// ==========================================================
// Control registers
reg [31:0] ctrl;
reg [LEVEL_W-1:0] nf_thr;
reg [LEVEL_W-1:0] ne_thr;
reg [`HAF_INT_W-1:0] int_status;
reg [`HAF_INT_W-1:0] int_mask;

assign software_reset_bit = ctrl[`HAF_CTRL_SWR_BIT];
assign decode_mode = ctrl[`HAF_CTRL_DECODE_BIT];

// ==========================================================
// FIFO service request and statistics ready
wire srq_cond;

// Encode: nearly full; decode: still at or below nearly empty
assign srq_cond = decode_mode ? (fifo_level <= ne_thr) :
    (fifo_level >= nf_thr);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        fifo_service_request <= 1'b0;
        statistics_ready <= 1'b0;
    end
    else if (software_reset_bit)
    begin
        // Held quiet while the core is in software reset
        fifo_service_request <= 1'b0;
        statistics_ready <= 1'b0;
    end
    else
    begin
        fifo_service_request <= srq_cond;
        // One update pulse per field; a new update beats a read
        if (stats_update)
            statistics_ready <= 1'b1;
        else if (stats_read)
            statistics_ready <= 1'b0;
    end
end

// ==========================================================
// Interrupt status and mask
wire [`HAF_INT_W-1:0] int_set;
reg [`HAF_INT_W-1:0] int_clr;

assign int_set = {statistics_ready, fifo_service_request};
assign host_interrupt_request = |(int_status & int_mask);

// ==========================================================
// AXI4-Lite write channel
reg aw_got;
reg w_got;
reg [`HAF_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write;

assign s_axi_awready = !aw_got && !s_axi_bvalid;
assign s_axi_wready = !w_got && !s_axi_bvalid;
assign do_write = aw_got && w_got && !s_axi_bvalid;

always @*
begin
    int_clr = {`HAF_INT_W{1'b0}};
    if (do_write && hit(aw_addr, `HAF_OFF_INT_STATUS) && w_strb[0])
        int_clr = w_data[`HAF_INT_W-1:0];
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        aw_addr <= {`HAF_ADDR_W{1'b0}};
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `HAF_RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (hit(aw_addr, `HAF_OFF_CTRL) ||
                hit(aw_addr, `HAF_OFF_THRESH) ||
                hit(aw_addr, `HAF_OFF_INT_STATUS) ||
                hit(aw_addr, `HAF_OFF_INT_MASK) ||
                hit(aw_addr, `HAF_OFF_LIVE))
                s_axi_bresp <= `HAF_RESP_OKAY;
            else
                s_axi_bresp <= `HAF_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ==========================================================
// Register writes with byte strobes
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ctrl <= `HAF_CTRL_RESET;
        nf_thr <= `HAF_NF_RESET;
        ne_thr <= `HAF_NE_RESET;
        int_mask <= `HAF_INT_MASK_RESET;
        int_status <= {`HAF_INT_W{1'b0}};
    end
    else
    begin
        // Set wins over a same-cycle write-one-to-clear
        int_status <= (int_status & ~int_clr) | int_set;
        if (do_write && hit(aw_addr, `HAF_OFF_CTRL) && w_strb[0])
            ctrl[7:0] <= {6'h00, w_data[1:0]};
        if (do_write && hit(aw_addr, `HAF_OFF_THRESH))
        begin
            if (w_strb[0])
                nf_thr[7:0] <= w_data[7:0];
            if (w_strb[1])
                nf_thr[LEVEL_W-1:8] <= w_data[LEVEL_W-1:8];
            if (w_strb[2])
                ne_thr[7:0] <= w_data[23:16];
            if (w_strb[3])
                ne_thr[LEVEL_W-1:8] <= w_data[LEVEL_W+15:24];
        end
        if (do_write && hit(aw_addr, `HAF_OFF_INT_MASK) && w_strb[0])
            int_mask <= w_data[`HAF_INT_W-1:0];
    end
end

// ==========================================================
// AXI4-Lite read channel
reg [31:0] rd_word;
reg rd_ok;

assign s_axi_arready = !s_axi_rvalid;

always @*
begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `HAF_OFF_CTRL))
        rd_word = {24'h000000, ctrl[7:0]};
    else if (hit(s_axi_araddr, `HAF_OFF_THRESH))
    begin
        rd_word[LEVEL_W-1:0] = nf_thr;
        rd_word[LEVEL_W+15:16] = ne_thr;
    end
    else if (hit(s_axi_araddr, `HAF_OFF_INT_STATUS))
        rd_word[`HAF_INT_W-1:0] = int_status;
    else if (hit(s_axi_araddr, `HAF_OFF_INT_MASK))
        rd_word[`HAF_INT_W-1:0] = int_mask;
    else if (hit(s_axi_araddr, `HAF_OFF_LIVE))
    begin
        rd_word[`HAF_INT_SRQ_BIT] = fifo_service_request;
        rd_word[`HAF_INT_STATS_BIT] = statistics_ready;
        rd_word[`HAF_LIVE_ACK_BIT] = host_ack_n;
        rd_word[LEVEL_W+15:16] = fifo_level;
    end
    else
        rd_ok = 1'b0;
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `HAF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `HAF_RESP_OKAY : `HAF_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // haf_top

// *** inc/haf_regs.vh ***
// Purpose: Constants for the host acknowledge / FIFO status block
// Assumes: AXI4-Lite register window of 256 bytes, 32-bit data
// Notes:   All offsets are byte addresses of aligned words
`ifndef HAF_REGS_VH
`define HAF_REGS_VH

// ==========================================================
// Register offsets
`define HAF_ADDR_W 8
`define HAF_OFF_CTRL 8'h00
`define HAF_OFF_THRESH 8'h04
`define HAF_OFF_INT_STATUS 8'h08
`define HAF_OFF_INT_MASK 8'h0c
`define HAF_OFF_LIVE 8'h10

// ==========================================================
// Field positions
`define HAF_CTRL_SWR_BIT 0
`define HAF_CTRL_DECODE_BIT 1
`define HAF_THR_NF_LSB 0
`define HAF_THR_NE_LSB 16
`define HAF_INT_SRQ_BIT 0
`define HAF_INT_STATS_BIT 1
`define HAF_LIVE_ACK_BIT 2
`define HAF_LIVE_LEVEL_LSB 16
`define HAF_INT_W 2

// ==========================================================
// Reset values
`define HAF_CTRL_RESET 32'h0000_0001
`define HAF_NF_RESET 10'h1c0
`define HAF_NE_RESET 10'h040
`define HAF_INT_MASK_RESET 2'h0

// ==========================================================
// AXI responses
`define HAF_RESP_OKAY 2'h0
`define HAF_RESP_SLVERR 2'h2

`endif

// *** testbench/haf_chk.sv ***
// Purpose: Port assertions for haf_top
// Assumes: Thresholds keep their reset values
// Notes:   Bound to every haf_top instance
`timescale 1ns/10ps
`include "haf_regs.vh"

// ====
// Checker
module haf_chk
#(
    parameter LEVEL_W = 10
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Host pins
    input wire host_cs_n,
    input wire host_wr_n,
    input wire host_rd_n,
    input wire host_cdata_sel,
    input wire host_data_oe,
    input wire host_ack_n,
    // Core side
    input wire [LEVEL_W-1:0] fifo_level,
    input wire fifo_full,
    input wire fifo_empty,
    input wire stats_update,
    input wire software_reset_bit,
    input wire decode_mode,
    input wire fifo_service_request,
    input wire statistics_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Edges for which a strobe has been held low under chip select
    reg [7:0] acc_cnt;
    wire acc = !host_cs_n && !(host_wr_n && host_rd_n);
    wire run = !software_reset_bit;
    always @(posedge aclk)
        acc_cnt <= (!aresetn || !acc) ? 8'h00 : acc_cnt + {7'h00, ~&acc_cnt};

    a_ack_wait: assert property (
        $fell(host_ack_n) && !host_cdata_sel |-> acc_cnt >= 8'h04)
        else $error("ack without wait cycle");
    a_full_hold: assert property (
        $fell(host_ack_n) && decode_mode && host_cdata_sel && !host_wr_n
        |-> !$past(fifo_full)) else $error("write done on full fifo");
    a_empty_hold: assert property (
        $fell(host_ack_n) && !decode_mode && host_cdata_sel && !host_rd_n
        |-> !$past(fifo_empty)) else $error("read done on empty fifo");
    a_srq_swr: assert property (
        software_reset_bit && $past(software_reset_bit)
        |-> !fifo_service_request) else $error("request in reset");
    a_srq_enc: assert property (
        (run && !decode_mode && fifo_level >= `HAF_NF_RESET) [*2]
        |-> fifo_service_request) else $error("no nearly-full request");
    a_srq_dec: assert property (
        (run && decode_mode && fifo_level > `HAF_NE_RESET) [*2]
        |-> !fifo_service_request) else $error("request above level");
    a_stats_set: assert property (
        stats_update && run |=> statistics_ready)
        else $error("stats ready missing");
    a_oe_cs: assert property (
        host_cs_n |-> !host_data_oe) else $error("bus driven unselected");
endmodule // haf_chk

bind haf_top haf_chk #(.LEVEL_W(LEVEL_W)) u_chk
(
    .aclk, .aresetn, .host_cs_n, .host_wr_n, .host_rd_n, .host_cdata_sel,
    .host_data_oe, .host_ack_n, .fifo_level, .fifo_full, .fifo_empty,
    .stats_update, .software_reset_bit, .decode_mode,
    .fifo_service_request, .statistics_ready
);

// *** testbench/haf_host_model.sv ***
// Purpose: Host bus master on the parallel pins
// Assumes: One access at a time
// Notes:   Unused data lines carry the inverse of the last value
`timescale 1ns/10ps

// ====
// Host model
module haf_host_model
(
    // Clock
    input wire aclk,
    // Host pins
    output reg host_cs_n,
    output reg host_wr_n,
    output reg host_rd_n,
    output reg host_cdata_sel,
    output reg [31:0] host_data_i,
    input wire [31:0] host_data_o,
    input wire host_ack_n
);
    initial
    begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_cdata_sel = 1'b0;
        host_data_i = 32'h0;
    end

    // Lat counts edges until acknowledge; 200 means no answer
    task access(input wr, input cd, input [31:0] d,
        output [31:0] q, output integer lat);
        begin
            lat = 0;
            @(posedge aclk);
            host_cs_n <= 1'b0;
            host_cdata_sel <= cd;
            host_data_i <= wr ? d : ~host_data_i;
            host_wr_n <= !wr;
            host_rd_n <= wr;
            @(posedge aclk);
            while (host_ack_n !== 1'b0 && lat < 200)
            begin
                @(posedge aclk);
                lat = lat + 1;
            end
            q = host_data_o;
            host_wr_n <= 1'b1;
            host_rd_n <= 1'b1;
            // Chip select outlives the strobe so the write commits
            repeat (5) @(posedge aclk);
            host_cs_n <= 1'b1;
            host_data_i <= ~host_data_i;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule // haf_host_model

// *** testbench/host_ack_fifo_status_test.sv ***
// Purpose: Self-checking bench for haf_top
// Assumes: Thresholds keep their reset values
// Notes:   Host pins come from haf_host_model
`timescale 1ns/10ps

// ====
// Bench
module host_ack_fifo_status_test;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, core_rdata, host_wr_data;
    logic [31:0] host_data_i, host_data_o, q, wr_seen;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, host_cs_n, host_wr_n, host_rd_n;
    logic host_cdata_sel, host_data_oe, host_ack_n, fifo_full, fifo_empty;
    logic stats_update, stats_read, host_wr_pulse, host_cdata_push;
    logic host_cdata_pop, software_reset_bit, decode_mode;
    logic fifo_service_request, statistics_ready, host_interrupt_request;
    logic [9:0] fifo_level;
    integer n_fail, n_compared, lat, n_push, n_pop, t;

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    haf_top #(.LEVEL_W(10)) DUT
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .host_cs_n, .host_wr_n, .host_rd_n,
        .host_cdata_sel, .host_data_i, .host_data_o, .host_data_oe,
        .host_ack_n, .fifo_level, .fifo_full, .fifo_empty, .stats_update,
        .stats_read, .core_rdata, .host_wr_data, .host_wr_pulse,
        .host_cdata_push, .host_cdata_pop, .software_reset_bit,
        .decode_mode, .fifo_service_request, .statistics_ready,
        .host_interrupt_request
    );

    haf_host_model u_host
    (
        .aclk, .host_cs_n, .host_wr_n, .host_rd_n, .host_cdata_sel,
        .host_data_i, .host_data_o, .host_ack_n
    );

    always @(posedge aclk)
    begin
        if (host_wr_pulse === 1'b1)
            wr_seen <= host_wr_data;
        n_push <= n_push + (host_cdata_push === 1'b1);
        n_pop <= n_pop + (host_cdata_pop === 1'b1);
    end

    // ====
    // Tasks
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            t = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            // No limit here: only the watchdog ends a wait
            while (s_axi_bvalid !== 1'b1)
            begin
                @(posedge aclk);
                t = t + 1;
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            // Response one cycle after both halves are taken
            chk("btime", 0, t > 3);
        end
    endtask

    task axi_rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            t = 0;
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (s_axi_rvalid !== 1'b1)
            begin
                @(posedge aclk);
                t = t + 1;
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            chk("rdata", e, s_axi_rdata);
            chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            chk("rtime", 0, t > 2);
        end
    endtask

    task lvl(input [9:0] l, input e);
        begin
            @(posedge aclk);
            fifo_level <= l;
            repeat (3) @(posedge aclk);
            chk("srq", {31'h0, e}, {31'h0, fifo_service_request});
        end
    endtask

    task pulse(input u);
        begin
            @(posedge aclk);
            stats_update <= u;
            stats_read <= !u;
            @(posedge aclk);
            stats_update <= 1'b0;
            stats_read <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask

    task test_done;
        begin
            $display("compared %0d failed %0d", n_compared, n_fail);
            if (n_fail == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail = n_fail + 1;
        test_done;
    end

    // ====
    // Tests
    initial
    begin
        {n_fail, n_compared, n_push, n_pop} = {4{32'h0}};
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, fifo_full, fifo_empty} = 4'h0;
        {stats_update, stats_read, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, fifo_level, wr_seen} = 74'h0;
        s_axi_wstrb = 4'hf;
        core_rdata = 32'hc0de_0a5a;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(8'h00, 32'h1, 2'h0);
        axi_rd(8'h04, 32'h0040_01c0, 2'h0);
        axi_rd(8'h0c, 32'h0, 2'h0);
        axi_rd(8'h14, 32'h0, 2'h2);
        axi_wr(8'h14, 32'hffff_ffff, 2'h2);
        lvl(10'h1c0, 1'b0);
        $display("test reset done");
        axi_wr(8'h00, 32'h0, 2'h0);
        chk("swr", 0, software_reset_bit);
        lvl(10'h1bf, 1'b0);
        lvl(10'h1c0, 1'b1);
        axi_rd(8'h08, 32'h1, 2'h0);
        axi_wr(8'h0c, 32'h1, 2'h0);
        chk("irq", 1, host_interrupt_request);
        lvl(10'h000, 1'b0);
        chk("irq", 1, host_interrupt_request);
        axi_wr(8'h08, 32'h1, 2'h0);
        chk("irq", 0, host_interrupt_request);
        $display("test encode request done");
        u_host.access(1'b1, 1'b0, 32'h5a5a_0f0f, q, lat);
        chk("wdata", 32'h5a5a_0f0f, wr_seen);
        // Two synchroniser stages plus at least one wait cycle
        chk("wait", 1, lat >= 4);
        chk("ack_n", 1, host_ack_n);
        u_host.access(1'b0, 1'b0, 32'h0, q, lat);
        chk("rdata", core_rdata, q);
        chk("wait", 1, lat >= 4);
        chk("oe", 0, host_data_oe);
        fifo_empty <= 1'b1;
        fork
            u_host.access(1'b0, 1'b1, 32'h0, q, lat);
            begin
                repeat (20) @(posedge aclk);
                fifo_empty <= 1'b0;
            end
        join
        chk("stall", 1, lat > 15 && lat < 200);
        chk("pop", 1, n_pop);
        $display("test host access done");
        axi_wr(8'h00, 32'h2, 2'h0);
        chk("dec", 1, decode_mode);
        lvl(10'h000, 1'b1);
        lvl(10'h041, 1'b0);
        axi_rd(8'h10, 32'h0041_0004, 2'h0);
        fifo_full <= 1'b1;
        fork
            u_host.access(1'b1, 1'b1, 32'h1234_abcd, q, lat);
            begin
                repeat (20) @(posedge aclk);
                fifo_full <= 1'b0;
            end
        join
        chk("stall", 1, lat > 15 && lat < 200);
        chk("push", 1, n_push);
        chk("wdata", 32'h1234_abcd, wr_seen);
        $display("test decode done");
        axi_wr(8'h0c, 32'h2, 2'h0);
        pulse(1'b1);
        chk("stats", 1, statistics_ready);
        chk("irq", 1, host_interrupt_request);
        pulse(1'b0);
        chk("stats", 0, statistics_ready);
        axi_wr(8'h08, 32'h2, 2'h0);
        chk("irq", 0, host_interrupt_request);
        pulse(1'b1);
        chk("stats", 1, statistics_ready);
        axi_wr(8'h00, 32'h3, 2'h0);
        lvl(10'h000, 1'b0);
        $display("test statistics done");
        test_done;
    end
endmodule // host_ack_fifo_status_test
